// File: rtl/cpm_clock_power.sv
// Clock source, PLL, divider and power-mode controller
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// ------------------------------------------------------------
module cpm_clock_power #(
	parameter int unsigned IRC_START_CYCLES = cpm_pkg::IRC_START_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        irc_tick,
	input  wire logic        main_tick,
	input  wire logic        rtc_tick,
	input  wire logic        wake_irq,
	input  wire logic        any_irq,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             cpu_clk_en,
	output logic             usb_clk_en,
	output logic [3:0]       periph_clk_en,
	output logic             rtc_clk_en,
	output logic             cpu_halted,
	output logic             irc_power_on,
	output logic             irc_out_en,
	output logic             main_osc_on,
	output logic             flash_power_on,
	output logic             flash_ready,
	output logic             pins_hold,
	output logic             core_power_on,
	output logic             pll_locked
);

	typedef enum logic [2:0] {
		ST_RUN, ST_IDLE, ST_SLEEP, ST_PDOWN, ST_DEEP, ST_IRCSTART, ST_RESUME
	} cpm_state_e;

	cpm_state_e  state_reg;
	logic        rst_n;
	logic        deep_wake_reg;
	logic [1:0]  src_reg;
	logic        pll_en_reg;
	logic        pll_con_reg;
	logic [7:0]  pll_n_reg;
	logic [14:0] pll_m_reg;
	logic [7:0]  cpu_div_reg;
	logic [7:0]  usb_div_reg;
	logic [3:0]  pconp_reg;
	logic [31:0] pclk_div_reg;
	logic [32:0] wr_view;
	logic [32:0] rd_view;
	logic [31:0] wv;
	logic        wr_go;
	logic        pm_req;
	logic        sleep_entry;
	logic        pd_entry;
	logic        pd_wake;
	logic        main_ready;
	logic [15:0] main_cnt;
	logic [15:0] wk_cnt;
	logic [15:0] flash_cnt;
	logic        flash_rdy_reg;
	logic        irc_g;
	logic        main_g;
	logic        pin_tick;
	logic        wake_tick;
	logic [1:0]  src_live;
	logic        con_live;
	logic [7:0]  n_cnt;
	logic        ref_p;
	logic [23:0] per_cnt;
	logic [23:0] per_reg;
	logic [23:0] acc;
	logic [24:0] acc_sum;
	logic [24:0] acc_dif;
	logic        cco_tick;
	logic [15:0] cco_cnt;
	logic [15:0] cco_now;
	logic [15:0] m_plus;
	logic [2:0]  lock_cnt;
	logic        lock_reg;
	logic        base_tick;
	logic [7:0]  cpu_cnt;
	logic [7:0]  usb_cnt;
	logic        cpu_tick;
	logic [7:0]  pcnt [cpm_pkg::NPERIPH];

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Divider counter step; fires on the tick that finds the counter at the limit and wraps it
	function automatic logic [7:0] cpm_div_step(input logic [7:0] c, input logic [7:0] lim, input logic t);
		if (!t)
			return c;
		return (c >= lim) ? 8'h00 : c + 8'h01;
	endfunction

	function automatic logic cpm_fires(input logic [7:0] c, input logic [7:0] lim, input logic t);
		return t && (c >= lim);
	endfunction

	// Byte-lane merge of a write into the current register view
	function automatic logic [31:0] cpm_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	// Register view: hit flag over read data
	function automatic logic [32:0] cpm_view(input logic [7:0] a);
		if (a == cpm_pkg::OFF_SRC)
			return {1'b1, 30'h0000_0000, src_reg};
		else if (a == cpm_pkg::OFF_PLLCTL)
			return {1'b1, 30'h0000_0000, pll_con_reg, pll_en_reg};
		else if (a == cpm_pkg::OFF_PLLCFG)
			return {1'b1, 9'h000, pll_m_reg, pll_n_reg};
		else if (a == cpm_pkg::OFF_STAT)
			return {1'b1, 27'h000_0000, flash_rdy_reg, main_ready, lock_reg, pll_con_reg, pll_en_reg};
		else if (a == cpm_pkg::OFF_CPUDIV)
			return {1'b1, 24'h00_0000, cpu_div_reg};
		else if (a == cpm_pkg::OFF_USBDIV)
			return {1'b1, 24'h00_0000, usb_div_reg};
		else if (a == cpm_pkg::OFF_PCONP)
			return {1'b1, 28'h000_0000, pconp_reg};
		else if (a == cpm_pkg::OFF_PCLKDIV)
			return {1'b1, pclk_div_reg};
		else if (a == cpm_pkg::OFF_PMODE)
			return {1'b1, 32'h0000_0000};
		return {1'b0, 32'h0000_0000};
	endfunction

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	// Address and data are taken together, single outstanding write
	assign wr_go   = awvalid && wvalid && !bvalid;
	assign awready = wr_go;
	assign wready  = wr_go;
	assign arready = !rvalid;
	// Procedural, so a register change also refreshes both views
	always_comb
	begin
		wr_view = cpm_view(awaddr);
		rd_view = cpm_view(araddr);
	end
	assign wv      = cpm_merge(wr_view[31:0], wdata, wstrb);

	// Write response
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			bvalid <= 1'b0;
			bresp  <= cpm_pkg::RESP_OK;
		end
		else if (wr_go)
		begin
			bvalid <= 1'b1;
			bresp  <= wr_view[32] ? cpm_pkg::RESP_OK : cpm_pkg::RESP_ERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// Read channel; unmapped reads return zero with an error
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= cpm_pkg::RESP_OK;
		end
		else if (arvalid && !rvalid)
		begin
			rvalid <= 1'b1;
			rdata  <= rd_view[31:0];
			rresp  <= rd_view[32] ? cpm_pkg::RESP_OK : cpm_pkg::RESP_ERR;
		end
		else if (rready)
			rvalid <= 1'b0;
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	assign pm_req      = wr_go && (awaddr == cpm_pkg::OFF_PMODE) && (state_reg == ST_RUN);
	assign sleep_entry = pm_req && (wv[2:0] == cpm_pkg::PM_SLEEP || wv[2:0] == cpm_pkg::PM_PDOWN);
	assign pd_entry    = pm_req && (wv[2:0] == cpm_pkg::PM_PDOWN);
	assign pd_wake     = (state_reg == ST_PDOWN) && wake_irq;

	// Source, PLL and divider settings; mode entries override writes
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			src_reg     <= cpm_pkg::SRC_IRC;
			pll_en_reg  <= 1'b0;
			pll_con_reg <= 1'b0;
			pll_n_reg   <= 8'h00;
			pll_m_reg   <= 15'h0000;
			cpu_div_reg <= 8'h00;
			usb_div_reg <= 8'h00;
		end
		else
		begin
			if (wr_go && awaddr == cpm_pkg::OFF_SRC && wv[1:0] != 2'h3)
				src_reg <= wv[1:0];
			if (wr_go && awaddr == cpm_pkg::OFF_PLLCTL)
			begin
				pll_en_reg  <= wv[cpm_pkg::PLLCTL_EN];
				pll_con_reg <= wv[cpm_pkg::PLLCTL_CON] && wv[cpm_pkg::PLLCTL_EN] && lock_reg;
			end
			else if (!lock_reg)
				pll_con_reg <= 1'b0;
			if (wr_go && awaddr == cpm_pkg::OFF_PLLCFG)
			begin
				pll_n_reg <= wv[cpm_pkg::CFG_N_LSB +: 8];
				pll_m_reg <= wv[cpm_pkg::CFG_M_LSB +: 15];
			end
			if (wr_go && awaddr == cpm_pkg::OFF_CPUDIV)
				cpu_div_reg <= wv[7:0];
			if (wr_go && awaddr == cpm_pkg::OFF_USBDIV)
				usb_div_reg <= wv[7:0];
			if (sleep_entry)
			begin
				pll_en_reg  <= 1'b0;
				pll_con_reg <= 1'b0;
				cpu_div_reg <= 8'h00;
				usb_div_reg <= 8'h00;
			end
			if (pd_wake)
				src_reg <= cpm_pkg::SRC_IRC;
		end
	end

	// Peripheral enables and dividers
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			pconp_reg    <= cpm_pkg::PCONP_RST;
			pclk_div_reg <= 32'h0000_0000;
		end
		else
		begin
			if (wr_go && awaddr == cpm_pkg::OFF_PCONP)
				pconp_reg <= wv[3:0];
			if (wr_go && awaddr == cpm_pkg::OFF_PCLKDIV)
				pclk_div_reg <= wv;
		end
	end

	// ------------------------------------------------------------
	// Power-mode sequencer
	// ------------------------------------------------------------
	// Deep power-down wake acts as a chip reset for everything but the RTC enable
	assign rst_n = aresetn && !deep_wake_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			deep_wake_reg <= 1'b0;
		else
			deep_wake_reg <= (state_reg == ST_DEEP) && wake_irq && !deep_wake_reg;
	end

	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_RUN;
			wk_cnt    <= 16'h0000;
		end
		else
		begin
			case (state_reg)
				ST_RUN:
				begin
					wk_cnt <= 16'h0000;
					if (pm_req && wv[2:0] == cpm_pkg::PM_IDLE)
						state_reg <= ST_IDLE;
					else if (pd_entry)
						state_reg <= ST_PDOWN;
					else if (sleep_entry)
						state_reg <= ST_SLEEP;
					else if (pm_req && wv[2:0] == cpm_pkg::PM_DEEP)
						state_reg <= ST_DEEP;
				end
				ST_IDLE:
					if (any_irq)
						state_reg <= ST_RUN;
				ST_SLEEP:
					if (wake_irq)
						state_reg <= ST_RESUME;
				ST_PDOWN:
					if (wake_irq)
						state_reg <= ST_IRCSTART;
				ST_IRCSTART:
				begin
					// RC start-up time counted on the system clock
					wk_cnt <= wk_cnt + 16'h0001;
					if (32'(wk_cnt) + 32'h0000_0001 >= IRC_START_CYCLES)
					begin
						wk_cnt    <= 16'h0000;
						state_reg <= ST_RESUME;
					end
				end
				ST_RESUME:
				begin
					if (wake_tick)
						wk_cnt <= wk_cnt + 16'h0001;
					if (wake_tick && wk_cnt + 16'h0001 >=
						(src_reg == cpm_pkg::SRC_MAIN ? cpm_pkg::WAKE_MAIN_TICKS : cpm_pkg::WAKE_IRC_TICKS))
						state_reg <= ST_RUN;
				end
				default:
					state_reg <= ST_DEEP;
			endcase
		end
	end

	// Supply and gating status from the mode
	assign cpu_halted     = (state_reg != ST_RUN);
	assign pins_hold      = (state_reg == ST_SLEEP) || (state_reg == ST_PDOWN) || (state_reg == ST_DEEP);
	assign irc_power_on   = (state_reg != ST_PDOWN) && (state_reg != ST_DEEP);
	assign irc_out_en     = irc_power_on && (state_reg != ST_SLEEP) && (state_reg != ST_IRCSTART);
	assign main_osc_on    = !pins_hold;
	assign flash_power_on = (state_reg != ST_PDOWN) && (state_reg != ST_DEEP) && (state_reg != ST_IRCSTART);
	assign core_power_on  = (state_reg != ST_DEEP);
	assign flash_ready    = flash_rdy_reg && flash_power_on;
	assign pll_locked     = lock_reg;

	// ------------------------------------------------------------
	// Oscillator stability and flash wake counters
	// ------------------------------------------------------------
	// Main oscillator unusable until it has run long enough
	always_ff @(posedge aclk)
	begin
		if (!rst_n || !main_osc_on)
			main_cnt <= 16'h0000;
		else if (main_tick && !main_ready)
			main_cnt <= main_cnt + 16'h0001;
	end

	assign main_ready = (main_cnt >= cpm_pkg::MAIN_STABLE);

	// Flash access granted after counted RC ticks
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			flash_cnt     <= 16'h0000;
			flash_rdy_reg <= 1'b1;
		end
		else if (!flash_power_on)
		begin
			flash_cnt     <= 16'h0000;
			flash_rdy_reg <= 1'b0;
		end
		else if (!flash_rdy_reg && irc_g)
		begin
			flash_cnt <= flash_cnt + 16'h0001;
			if (flash_cnt + 16'h0001 >= cpm_pkg::FLASH_TICKS)
				flash_rdy_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Source selection and PLL
	// ------------------------------------------------------------
	assign irc_g  = irc_tick && irc_out_en;
	assign main_g = main_tick && main_osc_on;

	// Main stays refused until the stability counter calls it stable
	assign pin_tick = (src_live == cpm_pkg::SRC_MAIN) ? (main_g && main_ready) :
	                  (src_live == cpm_pkg::SRC_RTC)  ? (rtc_tick && !pins_hold) : irc_g;

	// Main resume counts the restarted oscillator itself, else it would wait twice
	assign wake_tick = (src_live == cpm_pkg::SRC_MAIN) ? main_g : pin_tick;

	// Pre-divider by N (register holds N-1)
	always_ff @(posedge aclk)
	begin
		if (!rst_n || !pll_en_reg)
			n_cnt <= 8'h00;
		else if (pin_tick)
			n_cnt <= (n_cnt == pll_n_reg) ? 8'h00 : n_cnt + 8'h01;
	end

	assign ref_p   = pll_en_reg && pin_tick && (n_cnt == pll_n_reg);
	assign m_plus  = {1'b0, pll_m_reg} + 16'h0001;
	assign acc_sum = {1'b0, acc} + {9'h000, m_plus};
	assign acc_dif = acc_sum - {1'b0, per_reg};
	assign cco_tick = pll_en_reg && (per_reg != 24'h00_0000) && (acc_sum >= {1'b0, per_reg});
	assign cco_now = cco_cnt + {15'h0000, cco_tick};

	// Oscillator model: M ticks per reference period, compared per period
	always_ff @(posedge aclk)
	begin
		if (!rst_n || !pll_en_reg)
		begin
			per_cnt  <= 24'h00_0000;
			per_reg  <= 24'h00_0000;
			acc      <= 24'h00_0000;
			cco_cnt  <= 16'h0000;
			lock_cnt <= 3'h0;
			lock_reg <= 1'b0;
		end
		else
		begin
			per_cnt <= ref_p ? 24'h00_0000 : per_cnt + 24'h00_0001;
			if (ref_p)
				per_reg <= per_cnt + 24'h00_0001;
			if (!cco_tick)
				acc <= acc_sum[23:0];
			else if (acc_dif >= {1'b0, per_reg})
				acc <= 24'h00_0000; // saturated: out of range, never locks
			else
				acc <= acc_dif[23:0];
			cco_cnt <= ref_p ? 16'h0000 : cco_now;
			if (ref_p && cco_now == m_plus && per_reg != 24'h00_0000)
			begin
				if (lock_cnt == cpm_pkg::LOCK_REFS)
					lock_reg <= 1'b1;
				else
					lock_cnt <= lock_cnt + 3'h1;
			end
			else if (ref_p)
			begin
				lock_cnt <= 3'h0;
				lock_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// CPU, USB and peripheral clock enables
	// ------------------------------------------------------------
	assign base_tick = con_live ? cco_tick : pin_tick;
	assign cpu_tick  = cpm_fires(cpu_cnt, cpu_div_reg, base_tick);

	// Selection changes only at a divider boundary, so no short pulse
	always_ff @(posedge aclk)
	begin
		if (!rst_n)
		begin
			src_live <= cpm_pkg::SRC_IRC;
			con_live <= 1'b0;
		end
		else if (cpu_cnt == 8'h00 && usb_cnt == 8'h00)
		begin
			src_live <= src_reg;
			con_live <= pll_con_reg && lock_reg;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!rst_n || sleep_entry)
		begin
			cpu_cnt    <= 8'h00;
			usb_cnt    <= 8'h00;
			cpu_clk_en <= 1'b0;
			usb_clk_en <= 1'b0;
		end
		else
		begin
			cpu_cnt    <= cpm_div_step(cpu_cnt, cpu_div_reg, base_tick);
			usb_cnt    <= cpm_div_step(usb_cnt, usb_div_reg, base_tick);
			cpu_clk_en <= cpu_tick && (state_reg == ST_RUN);
			usb_clk_en <= cpm_fires(usb_cnt, usb_div_reg, base_tick) && (state_reg == ST_RUN || state_reg == ST_IDLE);
		end
	end

	// RTC enable keeps running through mode changes; only the pin reset stops it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rtc_clk_en <= 1'b0;
		else
			rtc_clk_en <= rtc_tick;
	end

	// Each peripheral divides the CPU rate on its own, gated by its enable
	for (genvar i = 0; i < cpm_pkg::NPERIPH; i++)
	begin : g_per
		always_ff @(posedge aclk)
		begin
			if (!rst_n || !pconp_reg[i])
			begin
				pcnt[i]          <= 8'h00;
				periph_clk_en[i] <= 1'b0;
			end
			else
			begin
				pcnt[i]          <= cpm_div_step(pcnt[i], pclk_div_reg[8*i +: 8], cpu_tick);
				periph_clk_en[i] <= cpm_fires(pcnt[i], pclk_div_reg[8*i +: 8], cpu_tick)
				                    && (state_reg == ST_RUN || state_reg == ST_IDLE);
			end
		end
	end

endmodule
`default_nettype wire

// File: common/cpm_pkg.sv
// Shared constants for the clock and power-mode controller
package cpm_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  OFF_SRC     = 8'h00;
	localparam logic [7:0]  OFF_PLLCTL  = 8'h04;
	localparam logic [7:0]  OFF_PLLCFG  = 8'h08;
	localparam logic [7:0]  OFF_STAT    = 8'h0C;
	localparam logic [7:0]  OFF_CPUDIV  = 8'h10;
	localparam logic [7:0]  OFF_USBDIV  = 8'h14;
	localparam logic [7:0]  OFF_PCONP   = 8'h18;
	localparam logic [7:0]  OFF_PCLKDIV = 8'h1C;
	localparam logic [7:0]  OFF_PMODE   = 8'h20;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int          PLLCTL_EN   = 0;
	localparam int          PLLCTL_CON  = 1;
	localparam int          CFG_N_LSB   = 0;
	localparam int          CFG_M_LSB   = 8;
	localparam int          ST_EN       = 0;
	localparam int          ST_CON      = 1;
	localparam int          ST_LOCK     = 2;
	localparam int          ST_MAINRDY  = 3;
	localparam int          ST_FLASHRDY = 4;
	localparam int          NPERIPH     = 4;
	localparam logic [3:0]  PCONP_RST   = 4'hF;
	localparam logic [1:0]  RESP_OK     = 2'h0;
	localparam logic [1:0]  RESP_ERR    = 2'h2;

	// Clock source codes
	localparam logic [1:0]  SRC_IRC     = 2'h0;
	localparam logic [1:0]  SRC_MAIN    = 2'h1;
	localparam logic [1:0]  SRC_RTC     = 2'h2;

	// Power mode request codes
	localparam logic [2:0]  PM_IDLE     = 3'h1;
	localparam logic [2:0]  PM_SLEEP    = 3'h2;
	localparam logic [2:0]  PM_PDOWN    = 3'h3;
	localparam logic [2:0]  PM_DEEP     = 3'h4;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          CLK_MHZ        = 100;
	localparam int          IRC_KHZ        = 4000;
	localparam int          IRC_START_NS   = 60000;
	localparam int          IRC_START_CYC  = (IRC_START_NS * CLK_MHZ + 999) / 1000;
	localparam int          FLASH_WAKE_NS  = 100000;
	localparam logic [15:0] FLASH_TICKS    = 16'((FLASH_WAKE_NS * IRC_KHZ + 999999) / 1000000);
	localparam logic [15:0] WAKE_IRC_TICKS = 16'h0004;
	localparam logic [15:0] WAKE_MAIN_TICKS = 16'h1000;
	localparam logic [15:0] MAIN_STABLE    = 16'h1000;
	localparam logic [2:0]  LOCK_REFS      = 3'h4;

endpackage

// File: testbench/cpm_clock_power_sva.sv
// Port-level checks for the clock and power-mode controller
`timescale 1ns/1ps
`default_nettype none
module cpm_clock_power_sva (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        any_irq,
	input wire logic        rtc_tick,
	input wire logic        awvalid,
	input wire logic        wvalid,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	input wire logic        arvalid,
	input wire logic [7:0]  araddr,
	input wire logic        rvalid,
	input wire logic [1:0]  rresp,
	input wire logic [31:0] rdata,
	input wire logic        cpu_clk_en,
	input wire logic        usb_clk_en,
	input wire logic [3:0]  periph_clk_en,
	input wire logic        rtc_clk_en,
	input wire logic        cpu_halted,
	input wire logic        irc_out_en,
	input wire logic        irc_power_on,
	input wire logic        flash_power_on,
	input wire logic        flash_ready,
	input wire logic        pins_hold,
	input wire logic        pll_locked,
	input wire logic        core_power_on
);
	// ------------------------------------------------------------
	// Single domain, so one clock and one disable for all
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_wr_answer: assert property (awvalid && wvalid && !bvalid |=> bvalid)
		else $error("write answer late");
	a_wr_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_rd_answer: assert property (arvalid && !rvalid |=> rvalid)
		else $error("read answer late");
	a_rd_unmapped: assert property (arvalid && !rvalid && araddr > 8'h20 |=> rresp == cpm_pkg::RESP_ERR && rdata == 0)
		else $error("unmapped read not refused");
	a_reset_state: assert property ($rose(aresetn) |-> irc_out_en && !pll_locked && !cpu_halted)
		else $error("bad state after reset");
	a_sleep_quiet: assert property (pins_hold && $past(pins_hold) |-> !cpu_clk_en && !usb_clk_en && !periph_clk_en)
		else $error("clock pulse while held");
	a_sleep_irc_gate: assert property (pins_hold |-> !irc_out_en)
		else $error("RC output live while held");
	a_rtc_follow: assert property ($past(aresetn) |-> rtc_clk_en == $past(rtc_tick))
		else $error("RTC clock not following");
	a_flash_kept: assert property (pins_hold && irc_power_on |-> flash_power_on)
		else $error("flash off in sleep");
	a_flash_wait: assert property (!irc_power_on |-> !flash_ready)
		else $error("flash ready without RC");
	a_idle_wake: assert property (cpu_halted && !pins_hold && irc_out_en && any_irq |=> !cpu_halted)
		else $error("idle not left on interrupt");
	a_halt_no_cpu: assert property (cpu_halted && $past(cpu_halted) |-> !cpu_clk_en)
		else $error("CPU pulse while halted");

	// Main scenarios reached
	c_idle: cover property (cpu_halted && !pins_hold && any_irq);
	c_pdown: cover property (pins_hold && !irc_power_on);
	c_lock: cover property ($rose(pll_locked));
	c_deep: cover property (!core_power_on);
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the clock and power-mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        aclk, aresetn, wake_irq, any_irq;
	logic        irc_tick = 1'b0, main_tick = 1'b0, rtc_tick = 1'b0;
	logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd_v;
	logic [3:0]  wstrb, periph_clk_en;
	logic [1:0]  bresp, rresp;
	logic        cpu_clk_en, usb_clk_en, rtc_clk_en, cpu_halted, irc_power_on, irc_out_en, main_osc_on;
	logic        flash_power_on, flash_ready, pins_hold, core_power_on, pll_locked;
	int          fails, cmp_count;
	int          cyc = 0;
	int          cnt[9] = '{default: 0};
	int          base[9];

	// Short start-up count keeps power-down wake quick
	cpm_clock_power #(.IRC_START_CYCLES(8)) cpm_clock_power_i (.*);

	// ------------------------------------------------------------
	// Clock, oscillator ticks and pulse counters
	// ------------------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Oscillators fall silent when powered off; RTC runs fast to keep the run short
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		irc_tick <= irc_power_on && (cyc % 25 == 0);
		main_tick <= main_osc_on && (cyc % 4 == 0);
		rtc_tick <= (cyc % 100 == 0);
		for (int k = 0; k < 9; k++)
			cnt[k] <= cnt[k] + int'({main_tick, irc_tick, usb_clk_en, rtc_clk_en, periph_clk_en, cpu_clk_en} >> k & 9'h1);
	end

	// ------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic rng(input string what, input int lo, input int hi, input int g);
		cmp_count++;
		if (g < lo || g > hi)
		begin
			fails++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, g);
		end
	endtask

	// Level looked at mid-cycle, where it is settled; returns just after the edge that takes it
	task automatic hs(ref logic s, input logic v, input string what);
		int n;
		n = 0;
		do
		begin
			@(negedge aclk);
			n++;
		end
		while (s !== v && n < 30000);
		@(posedge aclk);
		if (n >= 30000)
		begin
			fails++;
			$display("MISMATCH %s expected level seen timeout", what);
			give_verdict();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = cpm_pkg::RESP_OK);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		hs(awready, 1'b1, "awready");
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		hs(bvalid, 1'b1, "bvalid");
		bready <= 1'b0;
		chk("bresp", 32'(er), 32'(bresp));
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string what,
		input logic [1:0] er = cpm_pkg::RESP_OK);
		araddr <= a;
		arvalid <= 1'b1;
		hs(arready, 1'b1, "arready");
		arvalid <= 1'b0;
		rready <= 1'b1;
		hs(rvalid, 1'b1, "rvalid");
		rready <= 1'b0;
		rd_v = rdata;
		chk(what, e, rd_v & m);
		chk("rresp", 32'(er), 32'(rresp));
	endtask

	// Wake pulse, then count ticks of one oscillator until the CPU runs again
	task automatic wake(input int k, input int e, input string what);
		wake_irq <= 1'b1;
		@(posedge aclk);
		wake_irq <= 1'b0;
		base = cnt;
		hs(cpu_halted, 1'b0, what);
		rng(what, e, e + 2, cnt[k] - base[k]);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{aresetn, wake_irq, any_irq, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		{fails, cmp_count} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("pll_locked", 32'h0, 32'(pll_locked));
		rd(cpm_pkg::OFF_SRC, 32'h3, 32'(cpm_pkg::SRC_IRC), "src");
		rd(cpm_pkg::OFF_STAT, 32'h1F, 32'h10, "stat");
		rd(cpm_pkg::OFF_PCONP, 32'hF, 32'hF, "pconp");
		wr(8'h40, 32'h1, cpm_pkg::RESP_ERR);
		rd(8'h40, 32'hFFFF_FFFF, 32'h0, "unmapped", cpm_pkg::RESP_ERR);
		// Code 3 is not a source and leaves the last choice in place
		for (int i = 0; i < 4; i++)
		begin
			wr(cpm_pkg::OFF_SRC, 32'(i));
			rd(cpm_pkg::OFF_SRC, 32'h3, (i == 3) ? 32'h2 : 32'(i), "src code");
		end
		wr(cpm_pkg::OFF_SRC, 32'(cpm_pkg::SRC_IRC));
		wr(cpm_pkg::OFF_PCONP, 32'h5);
		wr(cpm_pkg::OFF_PCLKDIV, 32'h0003_0000);
		base = cnt;
		repeat (1000) @(posedge aclk);
		rng("cpu pulses", 39, 41, cnt[0] - base[0]);
		rng("periph0", cnt[0] - base[0], cnt[0] - base[0], cnt[1] - base[1]);
		rng("periph2", 9, 11, cnt[3] - base[3]);
		rng("periph off", 0, 0, cnt[2] - base[2] + cnt[4] - base[4]);
		// Connect before lock must be refused
		wr(cpm_pkg::OFF_PLLCFG, 32'h0000_0300);
		wr(cpm_pkg::OFF_PLLCTL, 32'h3);
		rd(cpm_pkg::OFF_STAT, 32'h6, 32'h0, "early connect");
		hs(pll_locked, 1'b1, "lock");
		wr(cpm_pkg::OFF_PLLCTL, 32'h3);
		rd(cpm_pkg::OFF_STAT, 32'h7, 32'h7, "connected");
		wr(cpm_pkg::OFF_CPUDIV, 32'h1);
		wr(cpm_pkg::OFF_PMODE, 32'(cpm_pkg::PM_IDLE));
		base = cnt;
		repeat (300) @(posedge aclk);
		chk("halted", 32'h1, 32'(cpu_halted));
		rng("idle cpu", 0, 1, cnt[0] - base[0]);
		rng("idle periph", 1, 300, cnt[1] - base[1]);
		any_irq <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("idle wake", 32'h0, 32'(cpu_halted));
		any_irq <= 1'b0;
		wr(cpm_pkg::OFF_PMODE, 32'(cpm_pkg::PM_SLEEP));
		base = cnt;
		repeat (500) @(posedge aclk);
		chk("sleep pins", 32'h1, 32'(pins_hold));
		chk("sleep rc", 32'h2, 32'({irc_power_on, irc_out_en}));
		chk("sleep flash", 32'h1, 32'(flash_power_on));
		rng("sleep pulses", 0, 2, cnt[0] + cnt[1] + cnt[6] - base[0] - base[1] - base[6]);
		rng("sleep rtc", 4, 6, cnt[5] - base[5]);
		wake(7, 4, "rc wake");
		rd(cpm_pkg::OFF_STAT, 32'h3, 32'h0, "pll after sleep");
		rd(cpm_pkg::OFF_CPUDIV, 32'hFF, 32'h0, "cpudiv");
		chk("lock off", 32'h0, 32'(pll_locked));
		repeat (17000) @(posedge aclk);
		rd(cpm_pkg::OFF_STAT, 32'h8, 32'h8, "main ready");
		wr(cpm_pkg::OFF_SRC, 32'(cpm_pkg::SRC_MAIN));
		wr(cpm_pkg::OFF_PMODE, 32'(cpm_pkg::PM_SLEEP));
		wake(8, 4096, "main wake");
		wr(cpm_pkg::OFF_PMODE, 32'(cpm_pkg::PM_PDOWN));
		repeat (3) @(posedge aclk);
		chk("pdown power", 32'h0, 32'({irc_power_on, flash_power_on, flash_ready}));
		wake(7, 4, "pdown wake");
		chk("flash early", 32'h0, 32'(flash_ready));
		rd(cpm_pkg::OFF_SRC, 32'h3, 32'(cpm_pkg::SRC_IRC), "src after pdown");
		repeat (10500) @(posedge aclk);
		chk("flash late", 32'h1, 32'(flash_ready));
		wr(cpm_pkg::OFF_PCONP, 32'h3);
		wr(cpm_pkg::OFF_PMODE, 32'(cpm_pkg::PM_DEEP));
		repeat (3) @(posedge aclk);
		chk("core power", 32'h0, 32'(core_power_on));
		wake(7, 0, "deep wake");
		repeat (2) @(posedge aclk);
		rd(cpm_pkg::OFF_PCONP, 32'hF, 32'hF, "pconp after deep");
		give_verdict();
	end
endmodule

bind cpm_clock_power cpm_clock_power_sva cpm_clock_power_sva_i (.*);
`default_nettype wire
